// ==== hdl/led_pwm_pkg.sv ====
// ----------------------------------------------------------------
// shared constants for the led pwm controller
// ----------------------------------------------------------------
package led_pwm_pkg;
  localparam int CHANNELS   = 18;
  localparam int GROUPS     = 6;
  localparam int GROUP_SIZE = 3;
  localparam int DUTY_W     = 16;
  localparam int PRE_W      = 7;

  // resolution select codes
  localparam logic [1:0] RES_8BIT  = 2'h0;
  localparam logic [1:0] RES_10BIT = 2'h1;
  localparam logic [1:0] RES_12BIT = 2'h2;
  localparam logic [1:0] RES_16BIT = 2'h3;

  // period masks per resolution
  localparam logic [15:0] MASK_8BIT  = 16'h00FF;
  localparam logic [15:0] MASK_10BIT = 16'h03FF;
  localparam logic [15:0] MASK_12BIT = 16'h0FFF;
  localparam logic [15:0] MASK_16BIT = 16'hFFFF;

  // one sixth of the period per resolution
  localparam logic [15:0] STEP_8BIT  = 16'h002A;
  localparam logic [15:0] STEP_10BIT = 16'h00AA;
  localparam logic [15:0] STEP_12BIT = 16'h02AA;
  localparam logic [15:0] STEP_16BIT = 16'h2AAA;

  // fault detect enable codes
  localparam logic [1:0] FDE_OFF_A = 2'h0;
  localparam logic [1:0] FDE_OFF_B = 2'h1;
  localparam logic [1:0] FDE_SHORT = 2'h2;
  localparam logic [1:0] FDE_OPEN  = 2'h3;

  // spread spectrum: tick accumulator, nominal half rate
  localparam logic [15:0] ACC_NOMINAL = 16'h8000;
  localparam logic [15:0] SPREAD_5    = 16'h0666;
  localparam logic [15:0] SPREAD_15   = 16'h1333;
  localparam logic [15:0] SPREAD_24   = 16'h1EB8;
  localparam logic [15:0] SPREAD_34   = 16'h2B85;
  localparam logic [15:0] SPREAD_STEP = 16'h0100;

  function automatic logic [15:0] res_mask(input logic [1:0] sel);
    case (sel)
      RES_8BIT:  res_mask = MASK_8BIT;
      RES_10BIT: res_mask = MASK_10BIT;
      RES_12BIT: res_mask = MASK_12BIT;
      default:   res_mask = MASK_16BIT;
    endcase
  endfunction

  function automatic logic [15:0] res_step(input logic [1:0] sel);
    case (sel)
      RES_8BIT:  res_step = STEP_8BIT;
      RES_10BIT: res_step = STEP_10BIT;
      RES_12BIT: res_step = STEP_12BIT;
      default:   res_step = STEP_16BIT;
    endcase
  endfunction
endpackage

// ==== hdl/timebase_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// period counter carrier between timebase and channel logic
// ----------------------------------------------------------------
interface timebase_if;
  logic [1:0]  osc_sel;
  logic [1:0]  res_sel;
  logic        spread_en;
  logic [1:0]  spread_range;
  logic [15:0] cnt;
  logic        start;

  modport source (input osc_sel, input res_sel, input spread_en, input spread_range,
                  output cnt, output start);
  modport sink   (output osc_sel, output res_sel, output spread_en, output spread_range,
                  input cnt, input start);
endinterface
`default_nettype wire

// ==== hdl/pwm_timebase.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// free-running pwm period counter with prescale and spread
// ----------------------------------------------------------------
module pwm_timebase
  import led_pwm_pkg::*;
(
  input  wire logic   clock_i,
  input  wire logic   rst_b_i,
  timebase_if.source  tb
);
  typedef struct packed {
    logic [15:0]        acc;
    logic [PRE_W-1:0]   div;
    logic [15:0]        cnt;
    logic               start;
    logic signed [16:0] dev;
    logic               up;
  } tb_state_t;

  tb_state_t tb_reg;
  tb_state_t tb_next;

  // ----------------------------------------------------------------
  // tick generation, counter and spread sweep
  // ----------------------------------------------------------------
  always_comb begin
    logic [16:0]        sum;
    logic [16:0]        inc;
    logic signed [16:0] lim;
    logic [PRE_W-1:0]   div_top;
    logic               tick;
    logic [15:0]        mask;
    sum     = '0;
    inc     = '0;
    lim     = '0;
    div_top = '0;
    tick    = 1'b0;
    mask    = res_mask(tb.res_sel);
    tb_next = tb_reg;
    tb_next.start = 1'b0;
    // deviation limit from range select [RULE11]
    case (tb.spread_range)
      2'h0:    lim = signed'({1'b0, SPREAD_5});
      2'h1:    lim = signed'({1'b0, SPREAD_15});
      2'h2:    lim = signed'({1'b0, SPREAD_24});
      default: lim = signed'({1'b0, SPREAD_34});
    endcase
    inc = tb.spread_en ? 17'({1'b0, ACC_NOMINAL} + tb_reg.dev) : {1'b0, ACC_NOMINAL};
    sum = 17'({1'b0, tb_reg.acc} + inc);
    tb_next.acc = sum[15:0];
    // oscillator select divides by 1, 2, 4 or 8 [RULE2]
    div_top = PRE_W'((8'h01 << tb.osc_sel) - 8'h01);
    if (sum[16]) begin
      if (tb_reg.div >= div_top) begin
        tb_next.div = '0;
        tick        = 1'b1;
      end else begin
        tb_next.div = PRE_W'(tb_reg.div + 1'b1);
      end
    end
    // period wraps at the selected resolution [RULE21]
    if (tick) begin
      if (tb_reg.cnt >= mask) begin
        tb_next.cnt   = '0;
        tb_next.start = 1'b1;
      end else begin
        tb_next.cnt = 16'(tb_reg.cnt + 16'h0001);
      end
    end
    // triangle sweep of the deviation, one SPREAD_STEP per period [RULE11]
    if (!tb.spread_en) begin
      tb_next.dev = '0;
      tb_next.up  = 1'b1;
    end else if (tb_next.start) begin
      if (tb_reg.up) begin
        tb_next.dev = 17'(tb_reg.dev + signed'({1'b0, SPREAD_STEP}));
        if (tb_next.dev >= lim) begin
          tb_next.dev = lim;
          tb_next.up  = 1'b0;
        end
      end else begin
        tb_next.dev = 17'(tb_reg.dev - signed'({1'b0, SPREAD_STEP}));
        if (tb_next.dev <= -lim) begin
          tb_next.dev = 17'(-lim);
          tb_next.up  = 1'b1;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tb_reg <= '{acc: 16'h0000, div: '0, cnt: 16'h0000, start: 1'b0,
                  dev: '0, up: 1'b1};
    end else begin
      tb_reg <= tb_next;
    end
  end

  assign tb.cnt   = tb_reg.cnt;
  assign tb.start = tb_reg.start;
endmodule
`default_nettype wire

// ==== hdl/led_pwm_phase_shutdown_ctrl.sv ====
// Functional notes
// [RULE1] reset state runs all channels at 8-bit resolution, fastest oscillator rate
// [RULE2] pwm frequency set by oscillator select and resolution select
// [RULE3] phase delay and clock phase off: all outputs turn on together
// [RULE4] phase delay enable staggers channel turn-on
// [RULE5] phase delay: six groups of three, each one sixth period later
// [RULE6] group clock phase select 0: whole output turns on at cycle start
// [RULE7] select 1: first current half still turns on at cycle start
// [RULE8] select 1: second current half turns off at cycle end
// [RULE9] stagger and half-current alignment work together
// [RULE10] enable 10 captures short status, 11 captures open status
// [RULE11] spread deviation of 5, 15, 24 or 34 percent by range
// [RULE12] duty modulates with 256, 1024, 4096 or 65536 steps
// [RULE13] shutdown keeps all held contents
// [RULE14] soft shutdown bit 0 switches all current sources off
// [RULE15] shutdown pin low holds hardware shutdown, analog off
// [RULE16] shutdown pin high releases hardware shutdown
// [RULE17] shutdown pin rising edge resets host interface, contents kept
// [RULE18] host access stays open during hardware shutdown
// [RULE19] host rewrites settings after a supply dip before raising pin
// [RULE20] enable codes 00 and 01 disable detection, one status kind held
// [RULE21] channel on while period counter below its duty
`timescale 1ns/1ps
`default_nettype none
module led_pwm_phase_shutdown_ctrl
  import led_pwm_pkg::*;
(
  input  wire logic                           clock_i,
  input  wire logic                           rst_b_i,
  input  wire logic                           run_not_soft_off_i,
  input  wire logic                           shutdown_pin_n_i,
  input  wire logic [1:0]                     oscillator_select_i,
  input  wire logic [1:0]                     pwm_resolution_select_i,
  input  wire logic                           phase_delay_enable_i,
  input  wire logic [GROUPS-1:0]              group_clock_phase_select_i,
  input  wire logic [1:0]                     fault_detect_enable_i,
  input  wire logic                           spread_enable_i,
  input  wire logic [1:0]                     spread_range_select_i,
  input  wire logic [CHANNELS-1:0][DUTY_W-1:0] duty_i,
  input  wire logic [CHANNELS-1:0]            channel_open_i,
  input  wire logic [CHANNELS-1:0]            channel_short_i,
  output logic      [CHANNELS-1:0]            first_half_on_o,
  output logic      [CHANNELS-1:0]            second_half_on_o,
  output logic      [CHANNELS-1:0]            channel_fault_status_o,
  output logic                                i2c_reset_o,
  output logic                                analog_enable_o,
  output logic                                period_start_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                sd_s1;
    logic                sd_s2;
    logic                sd_prev;
    logic                i2c_rst;
    logic                analog_en;
    logic [CHANNELS-1:0] open_s1;
    logic [CHANNELS-1:0] open_s2;
    logic [CHANNELS-1:0] short_s1;
    logic [CHANNELS-1:0] short_s2;
    logic [1:0]          fde_prev;
    logic [CHANNELS-1:0] status;
    logic [CHANNELS-1:0] out1;
    logic [CHANNELS-1:0] out2;
    logic                pstart;
  } ctrl_state_t;

  ctrl_state_t state_reg;
  ctrl_state_t state_next;

  timebase_if tb ();

  logic [15:0]               mask;
  logic [15:0]               step;
  logic                      active;
  logic [GROUPS-1:0][15:0]   grp_local;
  logic [CHANNELS-1:0]       on_first;
  logic [CHANNELS-1:0]       on_second;

  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  // configuration straight from the control inputs [RULE1]
  assign tb.osc_sel      = oscillator_select_i;
  assign tb.res_sel      = pwm_resolution_select_i;
  assign tb.spread_en    = spread_enable_i;
  assign tb.spread_range = spread_range_select_i;

  pwm_timebase u_timebase (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .tb      (tb.source)
  );

  assign mask   = res_mask(pwm_resolution_select_i);
  assign step   = res_step(pwm_resolution_select_i);
  // both shutdown kinds gate the current sources [RULE14] [RULE15]
  assign active = run_not_soft_off_i && state_reg.sd_s2;

  // ----------------------------------------------------------------
  // per-group position and per-channel compare
  // ----------------------------------------------------------------
  for (genvar g = 0; g < GROUPS; g++) begin : g_group
    localparam logic [15:0] GIDX = 16'(g);
    logic [15:0] offs;
    // group g lags by g sixths of the period [RULE4] [RULE5] [RULE3]
    assign offs         = phase_delay_enable_i ? 16'(step * GIDX) : 16'h0000;
    assign grp_local[g] = 16'(tb.cnt - offs) & mask;
    for (genvar k = 0; k < GROUP_SIZE; k++) begin : g_chan
      localparam int CH = g * GROUP_SIZE + k;
      logic [15:0] duty;
      logic [16:0] tail;
      // only the low resolution bits take part [RULE12]
      assign duty = duty_i[CH] & mask;
      assign tail = 17'({1'b0, grp_local[g]} + {1'b0, duty});
      // on while position below duty [RULE21] [RULE7]
      assign on_first[CH] = grp_local[g] < duty;
      // phase 2 ends with the cycle, else follows phase 1 [RULE6] [RULE8] [RULE9]
      assign on_second[CH] = group_clock_phase_select_i[g] ? (tail > {1'b0, mask})
                                                           : on_first[CH];
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // two-flop synchronisers for pin-side inputs
    state_next.sd_s1    = shutdown_pin_n_i;
    state_next.sd_s2    = state_reg.sd_s1;
    state_next.open_s1  = channel_open_i;
    state_next.open_s2  = state_reg.open_s1;
    state_next.short_s1 = channel_short_i;
    state_next.short_s2 = state_reg.short_s1;
    state_next.sd_prev  = state_reg.sd_s2;
    // pin high leaves hardware shutdown [RULE16] [RULE15]
    state_next.analog_en = state_reg.sd_s2;
    // rising pin edge resets host interface only [RULE17]
    state_next.i2c_rst = state_reg.sd_s2 && !state_reg.sd_prev;
    // capture on entry into a detect code [RULE10] [RULE20]
    state_next.fde_prev = fault_detect_enable_i;
    if (fault_detect_enable_i != state_reg.fde_prev) begin
      if (fault_detect_enable_i == FDE_SHORT) begin
        state_next.status = state_reg.short_s2;
      end else if (fault_detect_enable_i == FDE_OPEN) begin
        state_next.status = state_reg.open_s2;
      end
    end
    // outputs dark in shutdown, held contents untouched [RULE13] [RULE14]
    state_next.out1   = active ? on_first : '0;
    state_next.out2   = active ? on_second : '0;
    state_next.pstart = tb.start;
  end

  // state register; contents survive both shutdowns [RULE13] [RULE18]
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign first_half_on_o        = state_reg.out1;
  assign second_half_on_o       = state_reg.out2;
  assign channel_fault_status_o = state_reg.status;
  assign i2c_reset_o            = state_reg.i2c_rst;
  assign analog_enable_o        = state_reg.analog_en;
  assign period_start_o         = state_reg.pstart;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_soft_off_dark: assert property ( // [RULE14]
    @(posedge clock_i) disable iff (!rst_b_i)
    !run_not_soft_off_i |=> (first_half_on_o == '0) && (second_half_on_o == '0))
    else $error("outputs lit during soft shutdown");

  a_hw_off_dark: assert property ( // [RULE15]
    @(posedge clock_i) disable iff (!rst_b_i)
    $fell(state_reg.sd_s2) |-> ##1 (first_half_on_o == '0) && !analog_enable_o)
    else $error("outputs or analog on in hardware shutdown");

  a_pin_release: assert property ( // [RULE16]
    @(posedge clock_i) disable iff (!rst_b_i)
    $rose(shutdown_pin_n_i) ##1 shutdown_pin_n_i [*2] |=> analog_enable_o)
    else $error("hardware shutdown not released");

  a_i2c_reset_pulse: assert property ( // [RULE17]
    @(posedge clock_i) disable iff (!rst_b_i)
    $rose(state_reg.sd_s2) |=> i2c_reset_o ##1 !i2c_reset_o)
    else $error("host interface reset pulse wrong");

  a_groups_aligned: assert property ( // [RULE3]
    @(posedge clock_i) disable iff (!rst_b_i)
    !phase_delay_enable_i |-> (grp_local[0] == grp_local[GROUPS-1]))
    else $error("groups not aligned without phase delay");

  a_group_stagger: assert property ( // [RULE5]
    @(posedge clock_i) disable iff (!rst_b_i)
    (phase_delay_enable_i && tb.cnt == 16'h0000)
      |-> (grp_local[1] == (16'(16'h0000 - step) & mask)))
    else $error("group stagger wrong");

  a_short_capture: assert property ( // [RULE10]
    @(posedge clock_i) disable iff (!rst_b_i)
    (fault_detect_enable_i == FDE_SHORT && state_reg.fde_prev == FDE_OFF_A)
      |=> channel_fault_status_o == $past(state_reg.short_s2))
    else $error("short status not captured");

  a_status_hold: assert property ( // [RULE20]
    @(posedge clock_i) disable iff (!rst_b_i)
    (fault_detect_enable_i == FDE_OFF_A || fault_detect_enable_i == FDE_OFF_B)
      |=> $stable(channel_fault_status_o))
    else $error("status changed while detection disabled");

  a_zero_duty_dark: assert property ( // [RULE21]
    @(posedge clock_i) disable iff (!rst_b_i)
    ((duty_i[0] & mask) == 16'h0000) |=> !first_half_on_o[0] && !second_half_on_o[0])
    else $error("zero duty channel lit");

  c_period_wrap: cover property (
    @(posedge clock_i) disable iff (!rst_b_i) period_start_o);
  c_split_phase: cover property (
    @(posedge clock_i) disable iff (!rst_b_i)
    group_clock_phase_select_i[0] && second_half_on_o[0] && !first_half_on_o[0]);
  c_open_capture: cover property (
    @(posedge clock_i) disable iff (!rst_b_i)
    fault_detect_enable_i == FDE_OPEN && state_reg.fde_prev == FDE_OFF_A);
endmodule
`default_nettype wire

// ==== tb/led_string_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// led strings with open and short comparators
// ----------------------------------------------------------------
module led_string_model
  import led_pwm_pkg::*;
(
  input  wire logic [CHANNELS-1:0] open_fault_i,
  input  wire logic [CHANNELS-1:0] short_fault_i,
  input  wire logic                analog_enable_i,
  output logic      [CHANNELS-1:0] open_seen_o,
  output logic      [CHANNELS-1:0] short_seen_o
);
  // comparators are unpowered while the analog side is off
  assign open_seen_o  = analog_enable_i ? open_fault_i : '0;
  assign short_seen_o = analog_enable_i ? short_fault_i : '0;
endmodule
`default_nettype wire

// ==== tb/led_pwm_phase_shutdown_ctrl_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module led_pwm_phase_shutdown_ctrl_test;
  import led_pwm_pkg::*;
  logic                            clock, rst_b, run, pin_n, phase_delay_enable, spr_en, i2c_rst, analog_en;
  logic                            pstart;
  logic [1:0]                      osc, res, fde, spr_rng;
  logic [GROUPS-1:0]               ps;
  logic [CHANNELS-1:0][DUTY_W-1:0] duty;
  logic [CHANNELS-1:0]             open_f, short_f, open_s, short_s;
  logic [CHANNELS-1:0]             first_on, second_on, status;
  int                              n_fail = 0, samples_checked = 0, cycles = 0;
  int                              rise_f[CHANNELS], fall_s[CHANNELS];
  int                              hi_f[CHANNELS], hi_s[CHANNELS];
  int                              per, maxdev, cnt;
  int                              pct[4] = '{5, 15, 24, 34};

  led_pwm_phase_shutdown_ctrl u_dut (
    .clock_i(clock), .rst_b_i(rst_b), .run_not_soft_off_i(run), .shutdown_pin_n_i(pin_n),
    .oscillator_select_i(osc), .pwm_resolution_select_i(res), .phase_delay_enable_i(phase_delay_enable),
    .group_clock_phase_select_i(ps), .fault_detect_enable_i(fde), .spread_enable_i(spr_en),
    .spread_range_select_i(spr_rng), .duty_i(duty), .channel_open_i(open_s),
    .channel_short_i(short_s), .first_half_on_o(first_on), .second_half_on_o(second_on),
    .channel_fault_status_o(status), .i2c_reset_o(i2c_rst), .analog_enable_o(analog_en),
    .period_start_o(pstart));

  led_string_model u_leds (
    .open_fault_i(open_f), .short_fault_i(short_f), .analog_enable_i(analog_en),
    .open_seen_o(open_s), .short_seen_o(short_s));

  // ----------------------------------------------------------------
  // clock and run limit
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(negedge clock) begin
    cycles++;
    if (cycles == 95000) begin
      n_fail++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // next period start pulse, bounded
  task automatic wait_start();
    int i;
    i = 0;
    @(negedge clock);
    while (pstart !== 1'b1 && i < 70000) begin
      @(negedge clock);
      i++;
    end
  endtask

  task automatic measure(output int p);
    wait_start();
    p = 0;
    do begin
      @(negedge clock);
      p++;
    end while (pstart !== 1'b1 && p < 70000);
  endtask

  // one 8-bit period of edges, window opened late so group 0 turns on inside it
  task automatic scan();
    logic [CHANNELS-1:0] pf, p2;
    wait_start();
    repeat (470) @(negedge clock);
    pf = first_on;
    p2 = second_on;
    for (int c = 0; c < CHANNELS; c++) begin
      rise_f[c] = -1;
      fall_s[c] = -1;
      hi_f[c] = 0;
      hi_s[c] = 0;
    end
    for (int t = 0; t < 512; t++) begin
      @(negedge clock);
      for (int c = 0; c < CHANNELS; c++) begin
        if (first_on[c] === 1'b1 && pf[c] === 1'b0 && rise_f[c] < 0) rise_f[c] = t;
        if (second_on[c] === 1'b0 && p2[c] === 1'b1 && fall_s[c] < 0) fall_s[c] = t;
        hi_f[c] += int'(first_on[c] === 1'b1);
        hi_s[c] += int'(second_on[c] === 1'b1);
      end
      pf = first_on;
      p2 = second_on;
    end
  endtask

  // group 1 splits its halves, two clocks per counter step, 84 clocks per sixth
  task automatic check_scan(input int dly);
    int g, eff;
    for (int c = 0; c < CHANNELS; c++) begin
      g = c / GROUP_SIZE;
      eff = (c % 3 == 2) ? 16 : 4;
      check("first on time", hi_f[c], 2 * eff);
      check("second on time", hi_s[c], 2 * eff);
      check("turn on", rise_f[c], rise_f[0] + dly * 84 * g);
      if (g == 1) check("phase 2 end", fall_s[c], rise_f[c]);
      else check("phase 1 end", fall_s[c], rise_f[c] + 2 * eff);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    run = 1'b1;
    pin_n = 1'b1;
    {osc, res, fde, spr_rng} = 8'h00;
    phase_delay_enable = 1'b0;
    spr_en = 1'b0;
    ps = 6'h00;
    open_f = 18'h15A5A;
    short_f = 18'h2A5A5;
    for (int c = 0; c < CHANNELS; c++) begin
      duty[c] = (c % 3 == 0) ? 16'h0004 : (c % 3 == 1) ? 16'h0304 : 16'h0010;
    end
    repeat (12) @(negedge clock);
    check("outputs in reset", first_on | second_on | status, 32'h0);
    rst_b = 1'b1;
    // period length per oscillator code and for resolution codes 0 to 2
    for (int k = 0; k < 6; k++) begin
      osc = (k < 4) ? 2'(k) : 2'h0;
      res = (k < 4) ? 2'h0 : 2'(k - 3);
      measure(per);
      check("period", per, (k < 4) ? (512 << k) : (512 << (2 * (k - 3))));
    end
    res = 2'h0;
    ps = 6'h02;
    scan();
    check_scan(0);
    phase_delay_enable = 1'b1;
    scan();
    check_scan(1);
    phase_delay_enable = 1'b0;
    // fault capture by detect code
    fde = 2'h2;
    repeat (3) @(negedge clock);
    check("short capture", status, 18'h2A5A5);
    fde = 2'h3;
    repeat (3) @(negedge clock);
    check("open capture", status, 18'h15A5A);
    fde = 2'h1;
    open_f = 18'h3FFFF;
    repeat (4) @(negedge clock);
    check("held on off code", status, 18'h15A5A);
    fde = 2'h0;
    repeat (2) @(negedge clock);
    fde = 2'h2;
    repeat (3) @(negedge clock);
    check("short again", status, 18'h2A5A5);
    // soft shutdown keeps everything dark
    run = 1'b0;
    cnt = 0;
    @(negedge clock);
    repeat (600) begin
      @(negedge clock);
      cnt += int'(|(first_on | second_on));
    end
    check("soft off lit cycles", cnt, 0);
    check("status in soft off", status, 18'h2A5A5);
    run = 1'b1;
    // hardware shutdown and release
    pin_n = 1'b0;
    repeat (4) @(negedge clock);
    check("analog in shutdown", analog_en, 1'b0);
    check("outputs in shutdown", first_on | second_on, 32'h0);
    ps = 6'h02; // settings re-driven before release
    pin_n = 1'b1;
    cnt = 0;
    repeat (8) begin
      @(negedge clock);
      cnt += int'(i2c_rst === 1'b1);
    end
    check("interface reset pulses", cnt, 1);
    check("analog after release", analog_en, 1'b1);
    check("status after release", status, 18'h2A5A5);
    scan();
    check("on time after release", hi_f[0], 8);
    // spread spectrum ranges
    spr_en = 1'b1;
    for (int r = 0; r < 4; r++) begin
      spr_rng = 2'(r);
      maxdev = 0;
      repeat (6) begin
        measure(per);
        per = (per > 512) ? per - 512 : 512 - per;
        if (per > maxdev) maxdev = per;
      end
      check("spread moves", 32'(maxdev > 0), 1);
      check("spread bound", 32'(maxdev <= 512 * pct[r] / (100 - pct[r]) + 4), 1);
    end
    // zero duty keeps a channel dark, neighbours unaffected
    spr_en = 1'b0;
    duty[0] = 16'h0000;
    scan();
    check("zero duty on time", hi_f[0] + hi_s[0], 0);
    check("neighbour on time", hi_f[1], 8);
    complete_run();
  end
endmodule
`default_nettype wire
